// file: inc/g0_cmd_defs.svh
`ifndef G0_CMD_DEFS_SVH
`define G0_CMD_DEFS_SVH

// Register byte offsets
`define REG_CDB_LO      8'h00
`define REG_CDB_HI      8'h04
`define REG_CMD         8'h08
`define REG_EVENT       8'h0C
`define REG_STATUS      8'h10
`define REG_XFER        8'h14
`define REG_DEFECT      8'h18

// Command register fields
`define CMD_INIT_LSB    0
`define CMD_LUN_GIVEN   3
`define CMD_HW_ERR      4
`define CMD_BUS_FATAL   5
`define CMD_GO          8

// Event register fields
`define EV_BUS_FREE     0
`define EV_RESEL_TO     1
`define EV_PRIO_RES     2
`define EV_ABORT        3
`define EV_BDR          4
`define EV_BUS_RESET    5
`define EV_UA_SET       6

// Defect register fields
`define DEF_FACTORY     0
`define DEF_GO          1

// Opcodes
`define OP_TUR          8'h00
`define OP_REZERO       8'h01
`define OP_SENSE        8'h03
`define OP_FORMAT       8'h04
`define OP_NOP          8'h0D

// Status bytes
`define ST_GOOD         8'h00
`define ST_CHECK        8'h02
`define ST_BUSY         8'h08
`define ST_INTER        8'h10

// Sense keys and codes
`define KEY_NONE        4'h0
`define KEY_NOT_READY   4'h2
`define KEY_HW          4'h4
`define KEY_ILLEGAL     4'h5
`define KEY_UA          4'h6
`define KEY_ABORTED     4'hB
`define CODE_NONE       8'h00
`define CODE_NOT_RDY    8'h04
`define CODE_NO_CFG     8'h3E
`define CODE_CFG_FAIL   8'h4C
`define CODE_BAD_OP     8'h20
`define CODE_BAD_FIELD  8'h24
`define CODE_UA         8'h29
`define CODE_HW_XFER    8'h44
`define CODE_BUS_ERR    8'h47

// Configuration record states
`define CFG_IDLE        2'h0
`define CFG_READING     2'h1
`define CFG_FAILED      2'h2
`define CFG_DONE        2'h3

// Sense transfer lengths
`define SENSE_LEN       6'h30
`define SENSE_ZERO_LEN  6'h04

`endif

// file: inc/g0_cmd_pkg.sv
package g0_cmd_pkg;

    typedef logic [7:0] byte_t;

    typedef enum logic [1:0]
    {
        fmt_block,
        fmt_index,
        fmt_phys,
        fmt_bad
    } list_fmt_e;

endpackage : g0_cmd_pkg

// file: design/sync_two.sv
`timescale 1ns/1ps

module sync_two #(
    parameter int W = 1
) (
    input  wire logic         core_clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] stage;

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            stage <= '0;
            dout  <= '0;
        end
        else
        begin
            stage <= din;
            dout  <= stage;
        end
    end
endmodule : sync_two

// file: design/g0_cmd.sv
// Behaviour
// - Ready, configured, permitted: unit check GOOD.
// - Drive not ready: CHECK, key 2 code 04.
// - Configuration pending: BUSY, key 2 code 3E.
// - Configuration read failed: CHECK, key 4 code 4C.
// - Rezero homes head, clears latched faults.
// - Sense length is min(count, 48) for nonzero count.
// - Sense made on check, busy and bus events.
// - No unit number given, no sense made.
// - Sense kept until delivered or other command except NOP.
// - Abort, device reset, bus reset discard sense.
// - Sense fetch reports and clears unit attention.
// - Zero count sends four bytes, clears sense.
// - Sense fetch checks only on listed errors.
// - No stored sense plus hardware error: report, GOOD.
// - Format decodes flags, list code, interleave.
// - Format flag set requests parameter list.
// - Complete flag replaces grown list, else appends.
// - List codes 000, 100, 101 accepted.
// - Interleave ignored, blocks laid contiguously.
// - Host defects recorded into grown list.
// - Factory list read only, changes refused.
// - Linked success gives intermediate; stops otherwise.
`timescale 1ns/1ps
`include "g0_cmd_defs.svh"

module g0_cmd (
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic        wb_cyc,
    input  wire logic        wb_stb,
    input  wire logic        wb_we,
    input  wire logic [7:0]  wb_adr,
    input  wire logic [3:0]  wb_sel,
    input  wire logic [31:0] wb_wdata,
    output logic      [31:0] wb_rdata,
    output logic             wb_ack,
    input  wire logic        drive_ready,
    input  wire logic [1:0]  cfg_state,
    input  wire logic        drive_fault,
    output logic             head_home,
    output logic             format_start,
    output logic             param_list_req,
    output logic             grown_replace,
    output logic             grown_update
);
    logic [3:0]  pins_s;
    logic        rdy_s;
    logic [1:0]  cfg_s;
    logic        fault_s;
    logic [7:0]  cdb [6];
    logic [2:0]  init_id;
    logic        lun_given;
    logic        hw_err;
    logic        bus_fatal;
    logic [7:0]  status;
    logic [3:0]  res_key;
    logic [7:0]  res_code;
    logic [5:0]  xfer_len;
    logic        seek_fault;
    logic        link_active;
    logic        factory_refused;
    logic [3:0]  s_key [8];
    logic [7:0]  s_code [8];
    logic [7:0]  s_valid;
    logic [7:0]  ua;
    logic        wr;
    logic        exec;
    logic        ev_wr;
    logic        def_wr;
    logic [7:0]  next_status;
    logic [3:0]  next_key;
    logic [7:0]  next_code;
    logic [5:0]  next_len;
    logic        gen_sense;
    logic        clr_sense;
    logic        clr_ua;
    logic        do_home;
    logic        do_format;
    logic        fmt_ok;
    logic [31:0] next_rdata;
    logic        cmd_lo;
    logic [2:0]  cur_init;
    logic        cur_lun;
    logic        cur_hw;
    logic        cur_fatal;
    g0_cmd_pkg::list_fmt_e list_fmt;

    sync_two #(.W(4)) u_sync (
        .core_clk (core_clk),
        .rst      (rst),
        .din      ({drive_fault, cfg_state, drive_ready}),
        .dout     (pins_s)
    );
    assign rdy_s   = pins_s[0];
    assign cfg_s   = pins_s[2:1];
    assign fault_s = pins_s[3];

    function automatic g0_cmd_pkg::list_fmt_e decode_fmt(input logic [2:0] code);
        case (code)
            3'b000:  decode_fmt = g0_cmd_pkg::fmt_block;
            3'b100:  decode_fmt = g0_cmd_pkg::fmt_index;
            3'b101:  decode_fmt = g0_cmd_pkg::fmt_phys;
            default: decode_fmt = g0_cmd_pkg::fmt_bad;
        endcase
    endfunction : decode_fmt

    function automatic logic [5:0] sense_len(input logic [7:0] count);
        if (count == 8'h00)
            sense_len = `SENSE_ZERO_LEN;
        else if (count > {2'b00, `SENSE_LEN})
            sense_len = `SENSE_LEN;
        else
            sense_len = count[5:0];
    endfunction : sense_len

    assign wr     = wb_cyc & wb_stb & wb_we & ~wb_ack;
    assign exec   = wr & (wb_adr == `REG_CMD) & wb_sel[1] & wb_wdata[`CMD_GO];
    assign ev_wr  = wr & (wb_adr == `REG_EVENT) & wb_sel[0];
    assign def_wr = wr & (wb_adr == `REG_DEFECT) & wb_sel[0] & wb_wdata[`DEF_GO];

    // Qualifiers written alongside go apply to that same command
    assign cmd_lo    = wr & (wb_adr == `REG_CMD) & wb_sel[0];
    assign cur_init  = cmd_lo ? wb_wdata[`CMD_INIT_LSB +: 3] : init_id;
    assign cur_lun   = cmd_lo ? wb_wdata[`CMD_LUN_GIVEN] : lun_given;
    assign cur_hw    = cmd_lo ? wb_wdata[`CMD_HW_ERR] : hw_err;
    assign cur_fatal = cmd_lo ? wb_wdata[`CMD_BUS_FATAL] : bus_fatal;

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            wb_ack <= 1'b0;
        else
            wb_ack <= wb_cyc & wb_stb & ~wb_ack;
    end

    // CDB bytes and command qualifiers
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            for (int i = 0; i < 6; i++)
                cdb[i] <= 8'h00;
            init_id   <= 3'h0;
            lun_given <= 1'b0;
            hw_err    <= 1'b0;
            bus_fatal <= 1'b0;
        end
        else if (wr)
        begin
            for (int i = 0; i < 4; i++)
                if (wb_adr == `REG_CDB_LO && wb_sel[i])
                    cdb[i] <= wb_wdata[8*i +: 8];
            for (int i = 0; i < 2; i++)
                if (wb_adr == `REG_CDB_HI && wb_sel[i])
                    cdb[4+i] <= wb_wdata[8*i +: 8];
            if (wb_adr == `REG_CMD && wb_sel[0])
            begin
                init_id   <= wb_wdata[`CMD_INIT_LSB +: 3];
                lun_given <= wb_wdata[`CMD_LUN_GIVEN];
                hw_err    <= wb_wdata[`CMD_HW_ERR];
                bus_fatal <= wb_wdata[`CMD_BUS_FATAL];
            end
        end
    end

    assign list_fmt = decode_fmt(cdb[1][2:0]);
    assign fmt_ok   = ~cdb[1][4] | (list_fmt != g0_cmd_pkg::fmt_bad);

    // Command execution outcome
    always_comb
    begin
        next_status = `ST_GOOD;
        next_key    = `KEY_NONE;
        next_code   = `CODE_NONE;
        next_len    = 6'h00;
        gen_sense   = 1'b0;
        clr_sense   = 1'b0;
        clr_ua      = 1'b0;
        do_home     = 1'b0;
        do_format   = 1'b0;
        case (cdb[0])
            `OP_TUR:
            begin
                if (!rdy_s)
                begin
                    next_status = `ST_CHECK;
                    next_key    = `KEY_NOT_READY;
                    next_code   = `CODE_NOT_RDY;
                end
                else if (cfg_s == `CFG_IDLE || cfg_s == `CFG_READING)
                begin
                    next_status = `ST_BUSY;
                    next_key    = `KEY_NOT_READY;
                    next_code   = `CODE_NO_CFG;
                end
                else if (cfg_s == `CFG_FAILED)
                begin
                    next_status = `ST_CHECK;
                    next_key    = `KEY_HW;
                    next_code   = `CODE_CFG_FAIL;
                end
            end
            `OP_REZERO:
            begin
                if (!rdy_s)
                begin
                    next_status = `ST_CHECK;
                    next_key    = `KEY_NOT_READY;
                    next_code   = `CODE_NOT_RDY;
                end
                else
                    do_home = 1'b1;
            end
            `OP_SENSE:
            begin
                if (cdb[2] != 8'h00 || cdb[3] != 8'h00 || cdb[1][4:0] != 5'h00)
                begin
                    next_status = `ST_CHECK;
                    next_key    = `KEY_ILLEGAL;
                    next_code   = `CODE_BAD_FIELD;
                end
                else if (cur_fatal || (cur_hw && s_valid[cur_init]))
                begin
                    next_status = `ST_CHECK;
                    next_key    = cur_fatal ? `KEY_ABORTED : `KEY_HW;
                    next_code   = cur_fatal ? `CODE_BUS_ERR : `CODE_HW_XFER;
                end
                else
                begin
                    next_len  = sense_len(cdb[4]);
                    clr_sense = 1'b1;
                    if (ua[cur_init])
                    begin
                        next_key  = `KEY_UA;
                        next_code = `CODE_UA;
                        clr_ua    = 1'b1;
                    end
                    else if (s_valid[cur_init])
                    begin
                        next_key  = s_key[cur_init];
                        next_code = s_code[cur_init];
                    end
                    else if (cur_hw)
                    begin
                        next_key  = `KEY_HW;
                        next_code = `CODE_HW_XFER;
                    end
                end
            end
            `OP_FORMAT:
            begin
                if (!fmt_ok || cdb[2] != 8'h00)
                begin
                    next_status = `ST_CHECK;
                    next_key    = `KEY_ILLEGAL;
                    next_code   = `CODE_BAD_FIELD;
                end
                else if (!rdy_s)
                begin
                    next_status = `ST_CHECK;
                    next_key    = `KEY_NOT_READY;
                    next_code   = `CODE_NOT_RDY;
                end
                else
                    do_format = 1'b1;
            end
            `OP_NOP:
                next_status = `ST_GOOD;
            default:
            begin
                next_status = `ST_CHECK;
                next_key    = `KEY_ILLEGAL;
                next_code   = `CODE_BAD_OP;
            end
        endcase
        if (next_status != `ST_GOOD)
            gen_sense = cur_lun;
        else if (cdb[0] != `OP_NOP)
            clr_sense = 1'b1;
        if (next_status == `ST_GOOD && cdb[5][0])
            next_status = `ST_INTER;
    end

    // Outcome registers
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            status      <= `ST_GOOD;
            res_key     <= `KEY_NONE;
            res_code    <= `CODE_NONE;
            xfer_len    <= 6'h00;
            link_active <= 1'b0;
        end
        else if (exec)
        begin
            status      <= next_status;
            res_key     <= next_key;
            res_code    <= next_code;
            xfer_len    <= next_len;
            link_active <= (next_status == `ST_INTER);
        end
    end

    // Per-initiator sense store and unit attention
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            s_valid <= 8'h00;
            ua      <= 8'h00;
            for (int i = 0; i < 8; i++)
            begin
                s_key[i]  <= `KEY_NONE;
                s_code[i] <= `CODE_NONE;
            end
        end
        else if (exec)
        begin
            if (gen_sense)
            begin
                s_valid[cur_init] <= 1'b1;
                s_key[cur_init]   <= next_key;
                s_code[cur_init]  <= next_code;
            end
            else if (clr_sense)
                s_valid[cur_init] <= 1'b0;
            if (clr_ua)
                ua[cur_init] <= 1'b0;
        end
        else if (ev_wr)
        begin
            if (wb_wdata[`EV_BDR] || wb_wdata[`EV_BUS_RESET])
                s_valid <= 8'h00;
            else if (wb_wdata[`EV_ABORT])
                s_valid[init_id] <= 1'b0;
            else if (lun_given && (wb_wdata[`EV_BUS_FREE] || wb_wdata[`EV_RESEL_TO]
                     || wb_wdata[`EV_PRIO_RES]))
            begin
                s_valid[init_id] <= 1'b1;
                s_key[init_id]   <= `KEY_ABORTED;
                s_code[init_id]  <= `CODE_BUS_ERR;
            end
            if (wb_wdata[`EV_UA_SET])
                ua[init_id] <= 1'b1;
        end
    end

    // Fault latch: a new fault wins over a rezero clear
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            seek_fault <= 1'b0;
        else
            seek_fault <= fault_s | (seek_fault & ~(exec & do_home));
    end

    // Drive-side strobes and held format flags
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            head_home      <= 1'b0;
            format_start   <= 1'b0;
            param_list_req <= 1'b0;
            grown_replace  <= 1'b0;
        end
        else
        begin
            head_home    <= exec & do_home;
            format_start <= exec & do_format;
            if (exec & do_format)
            begin
                param_list_req <= cdb[1][4];
                grown_replace  <= cdb[1][3];
            end
        end
    end

    // Defect list edits: factory list never changes
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            grown_update    <= 1'b0;
            factory_refused <= 1'b0;
        end
        else
        begin
            grown_update <= def_wr & ~wb_wdata[`DEF_FACTORY];
            if (def_wr)
                factory_refused <= wb_wdata[`DEF_FACTORY];
        end
    end

    always_comb
    begin
        next_rdata = 32'h0000_0000;
        case (wb_adr)
            `REG_CDB_LO: next_rdata = {cdb[3], cdb[2], cdb[1], cdb[0]};
            `REG_CDB_HI: next_rdata = {16'h0000, cdb[5], cdb[4]};
            `REG_CMD:    next_rdata = {26'h0, bus_fatal, hw_err, lun_given, init_id};
            `REG_STATUS: next_rdata = {4'h0, s_valid[init_id], link_active, seek_fault,
                                       ua[init_id], res_code, 4'h0, res_key, status};
            `REG_XFER:   next_rdata = {cdb[3], cdb[4], 3'h0, cdb[1][2:0], cdb[1][3],
                                       cdb[1][4], 2'h0, xfer_len};
            `REG_DEFECT: next_rdata = {31'h0, factory_refused};
            default:     next_rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            wb_rdata <= 32'h0000_0000;
        else if (wb_cyc & wb_stb & ~wb_ack)
            wb_rdata <= next_rdata;
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    sequence tur_exec;
        exec && cdb[0] == `OP_TUR;
    endsequence

    tur_good_a: assert property (tur_exec and rdy_s && cfg_s == `CFG_DONE && !cdb[5][0]
        |=> status == `ST_GOOD) else $error("ready unit check not GOOD");
    tur_notrdy_a: assert property (tur_exec and !rdy_s
        |=> status == `ST_CHECK && res_key == `KEY_NOT_READY && res_code == `CODE_NOT_RDY)
        else $error("not ready answer wrong");
    tur_busy_a: assert property (tur_exec and rdy_s && cfg_s == `CFG_READING
        |=> status == `ST_BUSY && res_code == `CODE_NO_CFG) else $error("busy answer wrong");
    tur_cfgfail_a: assert property (tur_exec and rdy_s && cfg_s == `CFG_FAILED
        |=> status == `ST_CHECK && res_key == `KEY_HW && res_code == `CODE_CFG_FAIL)
        else $error("config fail answer wrong");
    home_pulse_a: assert property (exec && cdb[0] == `OP_REZERO && rdy_s
        |=> head_home ##1 !head_home) else $error("home pulse wrong");
    sense_len_a: assert property (exec && next_status == `ST_GOOD && cdb[0] == `OP_SENSE
        |=> xfer_len <= `SENSE_LEN && xfer_len != 6'h00) else $error("sense length wrong");
    sense_keep_a: assert property (exec && gen_sense
        |=> s_valid[init_id]) else $error("sense not stored");
    bus_reset_a: assert property (ev_wr && wb_wdata[`EV_BUS_RESET]
        |=> s_valid == 8'h00) else $error("sense kept after reset");
    link_stop_a: assert property (exec && next_status == `ST_CHECK
        |=> !link_active && status == `ST_CHECK) else $error("link not stopped");
endmodule : g0_cmd

// file: verification/drive_model.sv
`timescale 1ns/1ps

module drive_model (
    input  wire logic       core_clk,
    input  wire logic       rst,
    input  wire logic       want_ready,
    input  wire logic [1:0] want_cfg,
    input  wire logic       want_fault,
    input  wire logic       head_home,
    output logic            drive_ready,
    output logic      [1:0] cfg_state,
    output logic            drive_fault,
    output logic      [7:0] home_cnt
);
    // Spindle and configuration-record state as seen on the pins
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            drive_ready <= 1'b0;
            cfg_state   <= 2'h0;
            drive_fault <= 1'b0;
        end
        else
        begin
            drive_ready <= want_ready;
            cfg_state   <= want_cfg;
            drive_fault <= want_fault;
        end
    end

    // Head parks at cylinder 0 once per rezero
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            home_cnt <= 8'h00;
        else if (head_home)
            home_cnt <= home_cnt + 8'h01;
    end
endmodule : drive_model

// file: verification/tb_top.sv
`timescale 1ns/1ps
`include "g0_cmd_defs.svh"

module tb_top;
    logic        core_clk, rst, wb_cyc, wb_stb, wb_we, wb_ack;
    logic [7:0]  wb_adr;
    logic [3:0]  wb_sel;
    logic [31:0] wb_wdata, wb_rdata, q;
    logic        drive_ready, drive_fault, want_ready, want_fault;
    logic [1:0]  cfg_state, want_cfg;
    logic        head_home, format_start, param_list_req, grown_replace, grown_update;
    logic [7:0]  home_cnt, h0;
    int          err_total = 0, n_checks = 0, n_fmt = 0, n_grow = 0, i, n0;
    logic [7:0]  tst [5] = '{`ST_CHECK, `ST_BUSY, `ST_BUSY, `ST_CHECK, `ST_GOOD};
    logic [3:0]  tky [5] = '{4'h2, 4'h2, 4'h2, 4'h4, 4'h0};
    logic [7:0]  tcd [5] = '{8'h04, 8'h3E, 8'h3E, 8'h4C, 8'h00};
    logic [2:0]  tpn [5] = '{3'h3, 3'h4, 3'h5, 3'h6, 3'h7};
    logic [7:0]  tcn [4] = '{8'hFF, 8'h30, 8'h2F, 8'h00};
    logic [5:0]  tln [4] = '{6'h30, 6'h30, 6'h2F, 6'h04};
    logic [7:0]  tfb [5] = '{8'h10, 8'h1C, 8'h15, 8'h09, 8'h11};
    localparam logic [31:0] MF = 32'h00FF0FFF;
    localparam logic [31:0] MS = 32'h000000FF;
    localparam logic [47:0] SNS = 48'h00FF00000003;

    g0_cmd g0_cmd_inst (.core_clk(core_clk), .rst(rst), .wb_cyc(wb_cyc), .wb_stb(wb_stb),
        .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_wdata(wb_wdata),
        .wb_rdata(wb_rdata), .wb_ack(wb_ack), .drive_ready(drive_ready),
        .cfg_state(cfg_state), .drive_fault(drive_fault), .head_home(head_home),
        .format_start(format_start), .param_list_req(param_list_req),
        .grown_replace(grown_replace), .grown_update(grown_update));

    drive_model drive_model_inst (.core_clk(core_clk), .rst(rst), .want_ready(want_ready),
        .want_cfg(want_cfg), .want_fault(want_fault), .head_home(head_home),
        .drive_ready(drive_ready), .cfg_state(cfg_state), .drive_fault(drive_fault),
        .home_cnt(home_cnt));

    initial
    begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    always @(posedge core_clk)
    begin
        if (format_start === 1'b1)
            n_fmt++;
        if (grown_update === 1'b1)
            n_grow++;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        n_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("CHECK FAILED at %0t: %s", $time, msg);
        end
    endtask : chk

    task automatic give_verdict();
        $display("Checks %0d, mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : give_verdict

    task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge core_clk);
        wb_cyc   <= 1'b1;
        wb_stb   <= 1'b1;
        wb_we    <= we;
        wb_adr   <= a;
        wb_wdata <= d;
        for (k = 0; k < 50 && wb_ack !== 1'b1; k++)
            @(posedge core_clk);
        if (k == 50)
        begin
            chk(32'h0, 32'h1, "bus timeout");
            give_verdict();
        end
        q = wb_rdata;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we  <= 1'b0;
    endtask : bus

    // Load CDB, fire with flags, read back status
    task automatic ex(input logic [47:0] cdb, input logic [7:0] f);
        bus(1'b1, `REG_CDB_LO, cdb[31:0]);
        bus(1'b1, `REG_CDB_HI, {16'h0000, cdb[47:32]});
        bus(1'b1, `REG_CMD, {23'h000000, 1'b1, f});
        repeat (2) @(posedge core_clk);
        bus(1'b0, `REG_STATUS, 32'h0);
    endtask : ex

    task automatic st(input logic [7:0] s, input logic [3:0] k, input logic [7:0] c,
                      input logic [31:0] m);
        chk(q & m, {8'h00, c, 4'h0, k, s} & m, "status");
    endtask : st

    task automatic flag(input int b, input logic v);
        chk({31'h0, q[b]}, {31'h0, v}, "status flag");
    endtask : flag

    task automatic pin(input logic r, input logic [1:0] c, input logic f);
        @(posedge core_clk);
        want_ready <= r;
        want_cfg   <= c;
        want_fault <= f;
        repeat (5) @(posedge core_clk);
    endtask : pin

    task automatic ev(input logic [7:0] e);
        bus(1'b1, `REG_EVENT, {24'h0, e});
        bus(1'b0, `REG_STATUS, 32'h0);
    endtask : ev

    task automatic done(input string s);
        $display("test %s done", s);
    endtask : done

    initial
    begin
        rst = 1'b1;
        {wb_cyc, wb_stb, wb_we, want_ready, want_fault} = 5'h00;
        wb_adr = 8'h00;
        wb_sel = 4'hF;
        wb_wdata = 32'h0;
        want_cfg = 2'h0;
        repeat (8) @(posedge core_clk);
        rst <= 1'b0;
        for (i = 0; i < 5; i++)
        begin
            pin(tpn[i][2], tpn[i][1:0], 1'b0);
            ex(48'h0, 8'h08);
            st(tst[i], tky[i], tcd[i], (tst[i] == `ST_GOOD) ? MS : MF);
            flag(27, tst[i] != `ST_GOOD);
        end
        done("readiness");
        pin(1'b0, 2'h3, 1'b0);
        for (i = 0; i < 4; i++)
        begin
            ex(48'h0, 8'h08);
            ex({8'h00, tcn[i], 32'h00000003}, 8'h08);
            st(`ST_GOOD, 4'h0, 8'h00, MS);
            flag(27, 1'b0);
            bus(1'b0, `REG_XFER, 32'h0);
            chk({26'h0, q[5:0]}, {26'h0, tln[i]}, "sense length");
        end
        ex(48'h0, 8'h00);
        st(`ST_CHECK, 4'h0, 8'h00, MS);
        flag(27, 1'b0);
        done("sense length");
        ex(48'h0, 8'h08);
        ev(8'h08);
        flag(27, 1'b0);
        for (i = 0; i < 3; i++)
        begin
            ev(8'h01 << i);
            flag(27, 1'b1);
            ev(8'h08 << i);
            flag(27, 1'b0);
        end
        done("events");
        pin(1'b1, 2'h3, 1'b0);
        ex(48'h0, 8'h08);
        ev(8'h40);
        flag(24, 1'b1);
        ex(SNS, 8'h08);
        st(`ST_GOOD, 4'h6, 8'h29, MF);
        flag(24, 1'b0);
        ex(SNS, 8'h18);
        st(`ST_GOOD, 4'h4, 8'h44, MF);
        ex(SNS | 48'h10000, 8'h08);
        st(`ST_CHECK, 4'h5, 8'h24, MF);
        flag(27, 1'b1);
        ex(SNS, 8'h28);
        st(`ST_CHECK, 4'hB, 8'h47, MF);
        ex(SNS, 8'h18);
        st(`ST_CHECK, 4'h4, 8'h44, MF);
        done("sense errors");
        for (i = 0; i < 5; i++)
        begin
            n0 = n_fmt;
            // Formats keep the current attributes, so no mode select first
            ex({24'h003412, 8'h00, tfb[i], 8'h04}, 8'h08);
            if (i == 4)
            begin
                st(`ST_CHECK, 4'h5, 8'h24, MF);
                chk(n_fmt, n0, "format refused");
            end
            else
            begin
                st(`ST_GOOD, 4'h0, 8'h00, MS);
                chk(n_fmt, n0 + 1, "format start");
                bus(1'b0, `REG_XFER, 32'h0);
                chk(q & 32'hFFFF1F00, {16'h1234, 3'h0, tfb[i][2:0], tfb[i][3], tfb[i][4], 8'h00},
                    "format decode");
                chk({31'h0, param_list_req}, {31'h0, tfb[i][4]}, "param list");
                if (tfb[i][4])
                    chk({31'h0, grown_replace}, {31'h0, tfb[i][3]}, "replace");
            end
        end
        done("format");
        n0 = n_grow;
        bus(1'b1, `REG_DEFECT, 32'h3);
        bus(1'b0, `REG_DEFECT, 32'h0);
        chk({31'h0, q[0]}, 32'h1, "factory edit");
        chk(n_grow, n0, "factory pulse");
        bus(1'b1, `REG_DEFECT, 32'h2);
        bus(1'b0, `REG_DEFECT, 32'h0);
        chk({31'h0, q[0]}, 32'h0, "grown edit");
        chk(n_grow, n0 + 1, "grown pulse");
        done("defect lists");
        pin(1'b1, 2'h3, 1'b1);
        pin(1'b1, 2'h3, 1'b0);
        bus(1'b0, `REG_STATUS, 32'h0);
        flag(25, 1'b1);
        h0 = home_cnt;
        ex(48'h01, 8'h08);
        st(`ST_GOOD, 4'h0, 8'h00, MS);
        flag(25, 1'b0);
        chk({24'h0, home_cnt}, {24'h0, h0 + 8'h01}, "head home");
        done("rezero");
        ex(48'h010000000000, 8'h08);
        st(`ST_INTER, 4'h0, 8'h00, MS);
        flag(26, 1'b1);
        pin(1'b0, 2'h3, 1'b0);
        ex(48'h010000000000, 8'h08);
        st(`ST_CHECK, 4'h2, 8'h04, MF);
        flag(26, 1'b0);
        ex(48'h0D, 8'h09);
        flag(27, 1'b0);
        ex(48'h0D, 8'h08);
        flag(27, 1'b1);
        done("link");
        give_verdict();
    end
endmodule : tb_top
